// ==== verilog/hdc_dir_ctrl.sv ====
`timescale 1ns/1ns
`include "hdc_regs.svh"
module hdc_dir_ctrl
    import hdc_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `HDC_CYC_PER_MS
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Configuration switch
    input  wire logic [3:0] rate_sw_i,
    // Serial side, data only
    input  wire logic       ser_txd_i, // R02
    output logic            ser_rxd_o, // R02
    // Bus side
    input  wire logic       bus_rx_i,
    output logic            bus_tx_o,
    output logic            bus_de_o,
    output logic            tx_mode_o
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [3:0] sw_s1, sw_s2;
    logic       txd_s1, txd_s2, rx_s1, rx_s2;

    // A pulse shorter than one clock may slip past; far below any bit time
    // Pins come from outside the clock domain; idle line level is high
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_s1  <= 4'h0;
            sw_s2  <= 4'h0;
            txd_s1 <= 1'b1;
            txd_s2 <= 1'b1;
            rx_s1  <= 1'b1;
            rx_s2  <= 1'b1;
        end else begin
            sw_s1  <= rate_sw_i;
            sw_s2  <= sw_s1;
            txd_s1 <= ser_txd_i;
            txd_s2 <= txd_s1;
            rx_s1  <= bus_rx_i;
            rx_s2  <= rx_s1;
        end
    end

    // ****************************************************************
    // Rate decode
    // ****************************************************************
    hdc_turn_if turn_bus ();

    hdc_rate_dec #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_rate (
        .rate_sw_i (sw_s2),
        .turn      (turn_bus.decoder)
    );

    // ****************************************************************
    // Direction state machine
    // ****************************************************************
    hdc_mode_t   mode, next_mode;
    logic [31:0] idle_cnt, next_idle_cnt;
    logic        active;

    // Any low level on the transmit line is character activity
    assign active = ~txd_s2;

    always_comb begin
        next_mode     = mode;
        next_idle_cnt = idle_cnt;
        case (mode)
            HDC_RX: begin
                next_idle_cnt = 32'h0;
                if (active) begin
                    next_mode = HDC_TX; // R05
                end
            end
            HDC_TX: begin
                if (active) begin
                    next_idle_cnt = 32'h0; // R12
                end else if (idle_cnt + 32'h1 >= turn_bus.turn_cycles) begin
                    next_mode     = HDC_RX; // R06
                    next_idle_cnt = 32'h0;
                end else begin
                    next_idle_cnt = idle_cnt + 32'h1;
                end
            end
            default: begin
                next_mode     = HDC_RX;
                next_idle_cnt = 32'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode     <= HDC_RX;
            idle_cnt <= 32'h0;
        end else begin
            mode     <= next_mode;
            idle_cnt <= next_idle_cnt;
        end
    end

    // ****************************************************************
    // Data paths
    // ****************************************************************
    logic next_bus_tx, next_ser_rxd;

    // Transmit path is registered from txd_s2 in every state, like the state itself, so start bit leaves with the enable
    // R02: no modem control pins exist on this port
    always_comb begin
        next_bus_tx  = txd_s2;                          // R03
        next_ser_rxd = (mode == HDC_RX) ? rx_s2 : 1'b1; // R04
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_tx_o  <= 1'b1;
            ser_rxd_o <= 1'b1;
        end else begin
            bus_tx_o  <= next_bus_tx;
            ser_rxd_o <= next_ser_rxd;
        end
    end

    // Enable straight from state: driver on only in transmit mode
    assign bus_de_o  = (mode == HDC_TX); // R03 R04
    assign tx_mode_o = (mode == HDC_TX);

    // ****************************************************************
    // Check helpers
    // ****************************************************************
    // These feed only the assertions below and drive no output
    logic [31:0] idle_run, next_idle_run;
    logic [31:0] exp_ms;

    // Own count of consecutive idle samples, so the release check does not
    // lean on the timer that it judges; saturates so it cannot wrap
    always_comb begin
        if (!txd_s2) begin
            next_idle_run = 32'h0;
        end else if (idle_run == 32'hffff_ffff) begin
            next_idle_run = idle_run;
        end else begin
            next_idle_run = idle_run + 32'h1;
        end
    end

    // Register the run count
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_run <= 32'h0;
        end else begin
            idle_run <= next_idle_run;
        end
    end

    // Expected turnaround per switch code, kept apart from the decoder
    always_comb begin
        case (sw_s2)
            `HDC_SW_38400: exp_ms = `HDC_TA_MS_38400;
            `HDC_SW_19200: exp_ms = `HDC_TA_MS_19200;
            `HDC_SW_9600:  exp_ms = `HDC_TA_MS_9600;
            `HDC_SW_4800:  exp_ms = `HDC_TA_MS_4800;
            `HDC_SW_2400:  exp_ms = `HDC_TA_MS_2400;
            `HDC_SW_1200:  exp_ms = `HDC_TA_MS_1200;
            `HDC_SW_600:   exp_ms = `HDC_TA_MS_600;
            default:       exp_ms = `HDC_TA_MS_600;
        endcase
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_start;
        !txd_s2 && mode == HDC_RX;
    endsequence

    chk_enter_tx: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R05
        s_start |=> bus_de_o) else $error("transmit mode not entered");

    chk_rx_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R04
        mode == HDC_RX |-> !bus_de_o) else $error("driver on in receive mode");

    chk_restart: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R12
        (mode == HDC_TX && active) |=> idle_cnt == 32'h0) else $error("timer not restarted");

    chk_hold_tx: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R06
        (mode == HDC_TX && $fell(mode == HDC_TX) == 1'b0 && idle_cnt + 32'h1 <
         turn_bus.turn_cycles) |=> mode == HDC_TX) else $error("left transmit early");

    chk_data_fwd: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R03
        1'b1 |=> bus_tx_o == $past(txd_s2)) else $error("bus data mismatch");

    // Entry and release as seen at the mode register
    sequence s_entered;
        $rose(mode == HDC_TX);
    endsequence

    sequence s_released;
        $fell(mode == HDC_TX);
    endsequence

    // The start bit must leave together with the enable, not after it
    chk_start_bit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R03 R05
        s_entered |-> bus_de_o && !bus_tx_o) else $error("start bit not on bus");

    // Release only after a full idle run at the selected rate
    chk_full_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R06 R07
        s_released |-> idle_run >= turn_bus.turn_cycles) else $error("early release");

    // Bus data reaches the terminal only while the driver is off
    chk_rx_fwd: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R04
        mode == HDC_RX |=> ser_rxd_o == $past(rx_s2)) else $error("bus data not passed");

    chk_rx_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R04
        mode == HDC_TX |=> ser_rxd_o) else $error("bus data leaked in transmit mode");

    // Turnaround on the interface must follow the rate table
    chk_turn_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R01 R07
        turn_bus.turn_cycles == exp_ms * CYC_PER_MS) else $error("turnaround select wrong");
endmodule // hdc_dir_ctrl

// ==== verilog/hdc_regs.svh ====
// Function
// R01: Four-bit rate switch selects 38400 down to 600 baud by fixed codes.
// R02: Serial port is DCE with data lines only; no modem control lines used.
// R03: Device drives the differential bus while forwarding serial data onto it.
// R04: Bus driver released when idle or forwarding bus data to serial port.
// R05: Activity on serial transmit input enters transmit mode without delay.
// R06: Return to receive only after transmit input idle for full turnaround.
// R07: Turnaround is 1,1,2,4,7,14,28 ms for 38400 down to 600 baud.
// R08: Bus controller waits at least turnaround before answering a request.
// R09: Bus controller waits at least turnaround before its next request.
// R10: Attached modem must ignore request-to-send and data-terminal-ready.
// R11: Modem must be full duplex and pass the needed character size.
// R12: New activity during turnaround restarts the idle timer.
`ifndef HDC_REGS_SVH
`define HDC_REGS_SVH

// ****************************************************************
// Rate switch codes
// ****************************************************************
`define HDC_SW_38400 4'h0
`define HDC_SW_19200 4'h2
`define HDC_SW_9600  4'h4
`define HDC_SW_4800  4'h6
`define HDC_SW_2400  4'h8
`define HDC_SW_1200  4'ha
`define HDC_SW_600   4'hc

// ****************************************************************
// Timing
// ****************************************************************
`define HDC_CLK_MHZ       100
`define HDC_TA_MS_38400   1
`define HDC_TA_MS_19200   1
`define HDC_TA_MS_9600    2
`define HDC_TA_MS_4800    4
`define HDC_TA_MS_2400    7
`define HDC_TA_MS_1200    14
`define HDC_TA_MS_600     28
`define HDC_CYC_PER_MS    (`HDC_CLK_MHZ * 1000)

`endif

// ==== verilog/hdc_pkg.sv ====
package hdc_pkg;
    typedef enum logic [1:0] {
        HDC_RX = 2'b01,
        HDC_TX = 2'b10
    } hdc_mode_t;
endpackage

// ==== verilog/hdc_turn_if.sv ====
`timescale 1ns/1ns
// Turnaround select from rate decode to direction control
interface hdc_turn_if;
    logic [31:0] turn_cycles;
    modport decoder (output turn_cycles);
    modport ctrl    (input  turn_cycles);
endinterface

// ==== verilog/hdc_rate_dec.sv ====
`timescale 1ns/1ns
`include "hdc_regs.svh"
module hdc_rate_dec
    import hdc_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `HDC_CYC_PER_MS
) (
    // Switch
    input  wire logic [3:0] rate_sw_i,
    // Result
    hdc_turn_if.decoder     turn
);
    logic [31:0] ms;

    // Switch code to turnaround in ms; unlisted codes take the longest time as a safe choice
    always_comb begin
        case (rate_sw_i)
            `HDC_SW_38400: ms = `HDC_TA_MS_38400; // R01 R07
            `HDC_SW_19200: ms = `HDC_TA_MS_19200; // R01 R07
            `HDC_SW_9600:  ms = `HDC_TA_MS_9600;  // R01 R07
            `HDC_SW_4800:  ms = `HDC_TA_MS_4800;  // R01 R07
            `HDC_SW_2400:  ms = `HDC_TA_MS_2400;  // R01 R07
            `HDC_SW_1200:  ms = `HDC_TA_MS_1200;  // R01 R07
            `HDC_SW_600:   ms = `HDC_TA_MS_600;   // R01 R07
            default:       ms = `HDC_TA_MS_600;
        endcase
    end

    assign turn.turn_cycles = ms * CYC_PER_MS;
endmodule // hdc_rate_dec

// ==== verification/hdc_far_bus.sv ====
`timescale 1ns/1ns
// ****
// Bus controller on the far side
// ****
module hdc_far_bus (
    // Clock, reset, watched driver enable, answer wait
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        bus_de_i,
    input  wire logic [31:0] wait_i,
    // Receiver output, idle high by bus bias
    output logic             bus_rx_o
);
    logic [31:0] idle;
    logic        seen;
    // Answers after a quiet turnaround, then a short burst of 8 toggles
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle <= 32'h0;
            seen <= 1'b0;
            bus_rx_o <= 1'b1;
        end else if (bus_de_i) begin
            idle <= 32'h0;
            seen <= 1'b1;
            bus_rx_o <= 1'b1;
        end else if (seen && idle < wait_i + 32'h8) begin
            idle <= idle + 32'h1;
            bus_rx_o <= (idle < wait_i) ? 1'b1 : ~bus_rx_o;
        end else begin
            bus_rx_o <= 1'b1;
        end
    end
endmodule // hdc_far_bus

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
// ****
// Direction control bench
// ****
module testbench;
    logic        core_clk_i = 0;
    logic        rst_n_i = 0;
    logic [3:0]  rate_sw_i = 4'h0;
    logic        ser_txd_i = 1;
    logic        bus_rx_i, ser_rxd_o, bus_tx_o, bus_de_o, tx_mode_o, rxd_q;
    logic [2:0]  hist = 3'h7;
    logic [31:0] lf = 32'hcf3bf385;
    int n_mismatch = 0, compares = 0, cyc = 0, turn = 10, n, ntog;
    int codes[8] = '{0, 2, 4, 6, 8, 10, 12, 15};
    int ms[8] = '{1, 1, 2, 4, 7, 14, 28, 28};
    always #5 core_clk_i = ~core_clk_i;
    hdc_dir_ctrl #(.CYC_PER_MS(10)) u_hdc_dir_ctrl (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .rate_sw_i(rate_sw_i), .ser_txd_i(ser_txd_i),
        .ser_rxd_o(ser_rxd_o), .bus_rx_i(bus_rx_i), .bus_tx_o(bus_tx_o),
        .bus_de_o(bus_de_o), .tx_mode_o(tx_mode_o));
    hdc_far_bus u_hdc_far_bus (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .bus_de_i(bus_de_o), .wait_i(32'(turn)), .bus_rx_o(bus_rx_i));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("CHECK FAILED %0t count %0d", $time, got);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Input history for the 3-clock pass-through; cycle ceiling cuts a hang
    always @(posedge core_clk_i) begin
        hist <= {hist[1:0], ser_txd_i};
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            n_mismatch++;
            summarize();
        end
    end
    // Port monitors, looked at away from the sampling edge
    always @(negedge core_clk_i) begin
        if (rst_n_i) begin
            chk(bus_tx_o, hist[2], "bus data");
            chk(tx_mode_o, bus_de_o, "mode flag");
            if (bus_de_o) chk(ser_rxd_o, 1'b1, "rx not blocked");
        end
        if (ser_rxd_o !== rxd_q) ntog++;
        rxd_q = ser_rxd_o;
    end
    // Every rate code: burst, late restart pulse, turnaround, bus answer
    initial begin
        repeat (20) @(negedge core_clk_i);
        chk(bus_de_o, 1'b0, "reset driver");
        chk(ser_rxd_o, 1'b1, "reset rxd");
        rst_n_i = 1;
        for (int k = 0; k < 8; k++) begin
            rate_sw_i = codes[k][3:0];
            turn = ms[k] * 10;
            repeat (4) @(negedge core_clk_i);
            chk(bus_de_o, 1'b0, "idle driver");
            ser_txd_i = 0;
            repeat (3) @(negedge core_clk_i);
            chk(bus_de_o, 1'b1, "enter tx");
            for (int i = 0; i < 16; i++) begin
                lf = lfsr(lf);
                ser_txd_i = (i == 15) ? 1'b0 : lf[0];
                @(negedge core_clk_i);
            end
            ser_txd_i = 1;
            repeat (turn - 3) @(negedge core_clk_i);
            chk(bus_de_o, 1'b1, "early release");
            ser_txd_i = 0;
            @(negedge core_clk_i);
            ser_txd_i = 1;
            n = 0;
            while (bus_de_o && n < 400) begin
                @(negedge core_clk_i);
                n++;
            end
            ntog = 0;
            // Two sync stages plus one full idle run after the restart pulse
            chk_rng(n, turn + 2, turn + 2);
            repeat (turn + 20) @(negedge core_clk_i);
            chk_rng(ntog, 8, 8);
        end
        summarize();
    end
endmodule // testbench
